// ---- shared/tlrc_pkg.sv ----
// Purpose: constants for the tension loop run control block
// Assumes: 125 MHz system clock, 32-bit register port, byte addresses
// Notes:   register offsets are word aligned
package tlrc_pkg;
   localparam int unsigned CLK_HZ        = 125_000_000;
   localparam int unsigned HOLD_MS       = 3000;
   localparam int unsigned HOLD_CYCLES   = HOLD_MS * (CLK_HZ / 1000);

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_STATUS    = 8'h04;
   localparam logic [7:0] ADDR_SETPOINT  = 8'h08;
   localparam logic [7:0] ADDR_EDIT      = 8'h0C;
   localparam logic [7:0] ADDR_SPAN      = 8'h10;
   localparam logic [7:0] ADDR_SCALE     = 8'h14;
   localparam logic [7:0] ADDR_TRIM      = 8'h18;
   localparam logic [1:0] GAIN_PAGE      = 2'h1;
   localparam logic [3:0] GAIN_COUNT     = 4'hC;

   // control register bit positions
   localparam int CTRL_EN_CMD     = 0;
   localparam int CTRL_DIS_CMD    = 1;
   localparam int CTRL_PARAM      = 2;
   localparam int CTRL_ZERO_CAP   = 3;
   localparam int CTRL_SPAN_CAP   = 4;
   localparam int CTRL_SP_EXT     = 5;
   localparam int CTRL_FMT_LO     = 6;
   localparam int CTRL_PID        = 8;

   // synchronised pin positions
   localparam int PIN_RUN     = 0;
   localparam int PIN_SEL0    = 1;
   localparam int PIN_SEL1    = 2;
   localparam int PIN_SP_KEY  = 3;
   localparam int PIN_DOWN    = 4;
   localparam int PIN_CONFIRM = 5;
   localparam int PIN_EXIT    = 6;
   localparam int PIN_COUNT   = 7;

   // output idle format
   localparam logic [1:0] FMT_0V   = 2'h0;
   localparam logic [1:0] FMT_0MA  = 2'h1;
   localparam logic [1:0] FMT_4MA  = 2'h2;

   // reset value, 4 mA idle code and gain kind indices
   localparam logic [15:0] IDLE_4MA_CODE = 16'h3333;
   localparam logic [15:0] SCALE_RESET   = 16'h0100;
   localparam logic [1:0]  KIND_P        = 2'h0;
   localparam logic [1:0]  KIND_I        = 2'h1;
   localparam logic [1:0]  KIND_D        = 2'h2;
endpackage

// ---- hdl/tlrc_run_ctrl.sv ----
// Purpose: run state, gain set choice, setpoint source and calibration capture
// Assumes: loop arithmetic outside; its result arrives on loop_out_i
// Notes:   panel keys and digital inputs are asynchronous pins
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module tlrc_run_ctrl #(
   parameter int W           = 16,
   parameter int HOLD_CYCLES = tlrc_pkg::HOLD_CYCLES
) (
   // clock, reset, enable
   input  wire logic                          clock_i,
   input  wire logic                          rst_n_i,
   input  wire logic                          ce_i,
   // register port
   input  wire logic [7:0]                    addr_i,
   input  wire logic [31:0]                   wdata_i,
   input  wire logic                          wr_i,
   input  wire logic                          rd_i,
   output logic      [31:0]                   rdata_o,
   // digital input and panel pins
   input  wire logic                          run_req_pin_i,
   input  wire logic [1:0]                    gain_sel_pin_i,
   input  wire logic                          sp_key_pin_i,
   input  wire logic                          down_key_pin_i,
   input  wire logic                          confirm_key_pin_i,
   input  wire logic                          exit_key_pin_i,
   // measurement and loop side
   input  wire logic [W-1:0]                  meas_i,
   input  wire logic [W-1:0]                  ext_sp_i,
   input  wire logic [W-1:0]                  loop_out_i,
   input  wire logic [W-1:0]                  nv_setpoint_i,
   // outputs to drive, loop and storage
   output logic      [W-1:0]                  drive_o,
   output logic                               regulating_o,
   output logic      [W-1:0]                  kp_o,
   output logic      [W-1:0]                  ki_o,
   output logic      [W-1:0]                  kd_o,
   output logic      [W-1:0]                  trim_share_o,
   output logic      [W-1:0]                  setpoint_o,
   output logic      [W-1:0]                  offset_o,
   output logic      [W-1:0]                  span_force_o,
   output logic      [W-1:0]                  span_reading_o,
   output logic                               nv_store_o,
   output logic      [W-1:0]                  nv_data_o
);
   import tlrc_pkg::*;

   typedef struct packed {
      logic [PIN_COUNT-1:0] s1;
      logic [PIN_COUNT-1:0] s2;
      logic [PIN_COUNT-1:0] s3;
      logic [PIN_COUNT-1:0] clean;
      logic                 run;
      logic                 via_serial;
      logic                 param_mode;
      logic                 zero_act;
      logic                 span_act;
      logic                 sp_ext;
      logic [1:0]           out_fmt;
      logic                 pid_sh;
      logic                 act_pid;
      logic [1:0]           act_set;
      logic [11:0][W-1:0]   sh_gain;
      logic [11:0][W-1:0]   act_gain;
      logic [W-1:0]         sh_trim;
      logic [W-1:0]         act_trim;
      logic [W-1:0]         scale;
      logic [W-1:0]         sp_nv;
      logic [W-1:0]         sp_ram;
      logic                 ram_valid;
      logic                 nv_loaded;
      logic                 sp_edit;
      logic [W-1:0]         edit_val;
      logic [31:0]          sp_hold;
      logic [31:0]          dn_hold;
      logic [W-1:0]         offset;
      logic [W-1:0]         span_force;
      logic [W-1:0]         span_read;
      logic [W-1:0]         drive;
      logic                 regulating;
      logic [W-1:0]         kp;
      logic [W-1:0]         ki;
      logic [W-1:0]         kd;
      logic [W-1:0]         setpoint;
      logic                 nv_store;
      logic [W-1:0]         nv_data;
      logic [31:0]          rdata;
   } tlrc_state_s;

   localparam logic [31:0] HOLD_LAST = 32'(HOLD_CYCLES - 1);

   tlrc_state_s st;
   tlrc_state_s next_st;

   function automatic logic [3:0] gidx(input logic [1:0] set, input logic [1:0] kind);
      gidx = 4'(({2'h0, set} * 4'h3) + {2'h0, kind});
   endfunction

   // saturating hold counter, zero while the key is up
   function automatic logic [31:0] hold_step(input logic [31:0] cnt, input logic held);
      if (!held) begin
         hold_step = 32'h0;
      end else if (cnt == HOLD_LAST) begin
         hold_step = cnt;
      end else begin
         hold_step = cnt + 32'h1;
      end
   endfunction

   logic [PIN_COUNT-1:0] pins;
   logic [PIN_COUNT-1:0] rise;
   logic [W-1:0]         idle_val;
   logic [2*W-1:0]       ext_scaled;
   logic                 wr_ctrl;
   logic                 en_cmd;
   logic                 dis_cmd;
   logic                 sp_hold_cond;
   logic                 dn_hold_cond;
   logic                 sp_hold_done;
   logic                 dn_hold_done;
   logic                 gain_hit;
   logic [3:0]           gain_sel_idx;
   logic [W-1:0]         sp_internal;
   logic [W-1:0]         sp_next;

   assign pins = {exit_key_pin_i, confirm_key_pin_i, down_key_pin_i, sp_key_pin_i,
                  gain_sel_pin_i[1], gain_sel_pin_i[0], run_req_pin_i};
   // edges are taken from stage three against the filtered copy, once stages two and three agree
   assign rise         = (st.s2 == st.s3) ? (st.s3 & ~st.clean) : '0;
   assign ext_scaled   = ext_sp_i * st.scale;
   assign wr_ctrl      = wr_i && (addr_i == ADDR_CTRL);
   assign en_cmd       = wr_ctrl && wdata_i[CTRL_EN_CMD];
   assign dis_cmd      = wr_ctrl && wdata_i[CTRL_DIS_CMD];
   assign sp_hold_cond = st.clean[PIN_SP_KEY] && !st.sp_ext && !st.sp_edit;
   assign dn_hold_cond = st.clean[PIN_DOWN] && st.zero_act;
   assign sp_hold_done = sp_hold_cond && (st.sp_hold == HOLD_LAST - 32'h1);
   assign dn_hold_done = dn_hold_cond && (st.dn_hold == HOLD_LAST - 32'h1);
   assign gain_hit     = (addr_i[7:6] == GAIN_PAGE) && (addr_i[5:2] < GAIN_COUNT);
   assign gain_sel_idx = addr_i[5:2];
   assign sp_internal  = st.ram_valid ? st.sp_ram : st.sp_nv;

   always_comb begin
      case (st.out_fmt)
         FMT_4MA: idle_val = W'(IDLE_4MA_CODE);
         default: idle_val = '0;
      endcase
   end

   always_comb begin
      next_st          = st;
      next_st.nv_store = 1'b0;
      next_st.rdata    = 32'h0;

      // three-stage filter: a change counts once stages two and three agree
      next_st.s1 = pins;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      if (st.s2 == st.s3) begin
         next_st.clean = st.s3;
      end

      // restore the stored setpoint once after reset
      if (!st.nv_loaded) begin
         next_st.sp_nv     = nv_setpoint_i;
         next_st.nv_loaded = 1'b1;
      end

      // run state
      if (!st.run) begin
         if (en_cmd) begin
            next_st.run        = 1'b1;
            next_st.via_serial = 1'b1;
         end else if (st.clean[PIN_RUN]) begin
            next_st.run        = 1'b1;
            next_st.via_serial = 1'b0;
         end
         next_st.act_set = {st.clean[PIN_SEL1], st.clean[PIN_SEL0]};
      end else if (dis_cmd) begin
         next_st.run = 1'b0;
      end else if (!st.via_serial && !st.clean[PIN_RUN]) begin
         next_st.run = 1'b0;
      end

      // register writes
      if (wr_i) begin
         if (addr_i == ADDR_CTRL) begin
            next_st.param_mode = wdata_i[CTRL_PARAM];
            next_st.zero_act   = wdata_i[CTRL_ZERO_CAP];
            next_st.span_act   = wdata_i[CTRL_SPAN_CAP];
            next_st.sp_ext     = wdata_i[CTRL_SP_EXT];
            next_st.out_fmt    = wdata_i[CTRL_FMT_LO+1:CTRL_FMT_LO];
            next_st.pid_sh     = wdata_i[CTRL_PID];
         end
         if (addr_i == ADDR_SETPOINT && !st.sp_ext) begin
            next_st.sp_ram    = wdata_i[W-1:0];
            next_st.ram_valid = 1'b1;
         end
         if (addr_i == ADDR_EDIT) begin
            next_st.edit_val = wdata_i[W-1:0];
         end
         if (addr_i == ADDR_SPAN && st.span_act) begin
            next_st.span_force = wdata_i[W-1:0];
            next_st.span_read  = meas_i - st.offset;
         end
         if (addr_i == ADDR_SCALE) begin
            next_st.scale = wdata_i[W-1:0];
         end
         if (addr_i == ADDR_TRIM) begin
            next_st.sh_trim = wdata_i[W-1:0];
         end
         if (gain_hit) begin
            next_st.sh_gain[gain_sel_idx] = wdata_i[W-1:0];
         end
      end

      // edits reach the loop and drop the volatile setpoint on leaving parameter mode
      if (st.param_mode && !next_st.param_mode) begin
         next_st.act_gain  = st.sh_gain;
         next_st.act_trim  = st.sh_trim;
         next_st.act_pid   = st.pid_sh;
         next_st.ram_valid = 1'b0;
      end

      // key holds
      next_st.sp_hold = hold_step(st.sp_hold, sp_hold_cond);
      next_st.dn_hold = hold_step(st.dn_hold, dn_hold_cond);
      if (sp_hold_done) begin
         next_st.sp_edit = 1'b1;
      end
      if (dn_hold_done) begin
         next_st.offset = meas_i;
      end
      if (st.sp_edit) begin
         if (rise[PIN_CONFIRM]) begin
            next_st.sp_edit   = 1'b0;
            next_st.sp_nv     = st.edit_val;
            next_st.ram_valid = 1'b0;
            next_st.nv_store  = 1'b1;
            next_st.nv_data   = st.edit_val;
         end else if (rise[PIN_EXIT]) begin
            next_st.sp_edit   = 1'b0;
            next_st.sp_ram    = st.edit_val;
            next_st.ram_valid = 1'b1;
         end
      end

      // setpoint source, updated every cycle whether running or not
      sp_next = st.sp_ext ? ext_scaled[W+7:8] : sp_internal;
      next_st.setpoint = sp_next;

      // drive output and indicator
      next_st.drive      = st.run ? loop_out_i : idle_val;
      next_st.regulating = st.run;
      next_st.kp = st.act_gain[gidx(st.act_set, KIND_P)];
      next_st.ki = st.act_gain[gidx(st.act_set, KIND_I)];
      next_st.kd = st.act_pid ? st.act_gain[gidx(st.act_set, KIND_D)] : '0;

      // read port, data in the following cycle
      if (rd_i) begin
         if (addr_i == ADDR_CTRL) begin
            next_st.rdata = 32'({st.pid_sh, st.out_fmt, st.sp_ext, st.span_act,
                                 st.zero_act, st.param_mode, 2'h0});
         end else if (addr_i == ADDR_STATUS) begin
            next_st.rdata = 32'({st.nv_loaded, st.act_set, st.sp_edit,
                                 st.via_serial, st.run});
         end else if (addr_i == ADDR_SETPOINT) begin
            next_st.rdata = 32'(st.setpoint);
         end else if (addr_i == ADDR_EDIT) begin
            next_st.rdata = 32'(st.edit_val);
         end else if (addr_i == ADDR_SPAN) begin
            next_st.rdata = 32'(st.span_force);
         end else if (addr_i == ADDR_SCALE) begin
            next_st.rdata = 32'(st.scale);
         end else if (addr_i == ADDR_TRIM) begin
            next_st.rdata = 32'(st.sh_trim);
         end else if (gain_hit) begin
            next_st.rdata = 32'(st.sh_gain[gain_sel_idx]);
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st       <= '0;
         st.scale <= W'(SCALE_RESET);
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign rdata_o        = st.rdata;
   assign drive_o        = st.drive;
   assign regulating_o   = st.regulating;
   assign kp_o           = st.kp;
   assign ki_o           = st.ki;
   assign kd_o           = st.kd;
   assign trim_share_o   = st.act_trim;
   assign setpoint_o     = st.setpoint;
   assign offset_o       = st.offset;
   assign span_force_o   = st.span_force;
   assign span_reading_o = st.span_read;
   assign nv_store_o     = st.nv_store;
   assign nv_data_o      = st.nv_data;

   property p_idle_off;
      @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && !st.run) |=> (drive_o == $past(idle_val) && !regulating_o);
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("idle level missing while off");

   property p_reg_on;
      @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && st.run) |=> (regulating_o && drive_o == $past(loop_out_i));
   endproperty
   a_reg_on: assert property (p_reg_on) else $error("regulating output wrong");

   property p_serial_hold;
      @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && st.run && st.via_serial && !dis_cmd) |=> st.run;
   endproperty
   a_serial_hold: assert property (p_serial_hold) else $error("serial run dropped");

   property p_set_frozen;
      @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && st.run) |=> $stable(st.act_set);
   endproperty
   a_set_frozen: assert property (p_set_frozen) else $error("set changed while running");

   property p_set_decode;
      @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && !st.run) |=> (st.act_set == $past({st.clean[PIN_SEL1], st.clean[PIN_SEL0]}));
   endproperty
   a_set_decode: assert property (p_set_decode) else $error("set index decode wrong");

   property p_pi_no_d;
      @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && !st.act_pid) |=> (kd_o == '0);
   endproperty
   a_pi_no_d: assert property (p_pi_no_d) else $error("derivative used in PI");

   property p_param_hold;
      @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && st.param_mode && next_st.param_mode) |=> $stable(st.act_gain);
   endproperty
   a_param_hold: assert property (p_param_hold) else $error("gain applied in param mode");

   property p_hold_clear;
      @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && !st.clean[PIN_SP_KEY]) |=> (st.sp_hold == 32'h0);
   endproperty
   a_hold_clear: assert property (p_hold_clear) else $error("hold count not cleared");

   property p_edit_enter;
      @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && sp_hold_done) |=> st.sp_edit;
   endproperty
   a_edit_enter: assert property (p_edit_enter) else $error("edit mode not entered");

   property p_confirm_store;
      @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && st.sp_edit && rise[PIN_CONFIRM]) |=> (nv_store_o && nv_data_o == $past(st.edit_val));
   endproperty
   a_confirm_store: assert property (p_confirm_store) else $error("confirm did not store");
endmodule

// ---- verification/tlrc_far_side.sv ----
// Purpose: far side model: loop engine result and nonvolatile setpoint memory
// Assumes: one clock domain shared with the run control block
// Notes:   memory keeps its content across reset, as real nonvolatile storage
`timescale 1ns/1ps
module tlrc_far_side #(
   parameter int             W       = 16,
   parameter logic [W-1:0]   NV_INIT = 16'h0123
) (
   // clock
   input  wire logic         clock_i,
   // from the run control block
   input  wire logic [W-1:0] setpoint_i,
   input  wire logic [W-1:0] kp_i,
   input  wire logic         nv_store_i,
   input  wire logic [W-1:0] nv_data_i,
   // to the run control block
   output logic      [W-1:0] loop_out_o,
   output logic      [W-1:0] nv_setpoint_o
);
   logic [W-1:0] nv_mem = NV_INIT;

   // engine stand-in: result depends on setpoint and active gain
   assign loop_out_o    = setpoint_i + kp_i;
   assign nv_setpoint_o = nv_mem;

   // stores on every clock edge where nv_store_i is high, so a held level stores each cycle
   always @(posedge clock_i) begin
      if (nv_store_i) begin
         nv_mem <= nv_data_i;
      end
   end
endmodule

// ---- verification/tension_loop_run_control_tb.sv ----
// Purpose: self-checking bench for the run control block
// Assumes: hold count shortened to 20 cycles, pins settle within 8 edges
// Notes:   after the idle format sweep, output format stays at 4 mA so idle differs from zero
`timescale 1ns/1ps
module tension_loop_run_control_tb;
   import tlrc_pkg::*;
   localparam int          W    = 16;
   localparam logic [15:0] NV0  = 16'h0123;
   localparam logic [31:0] BASE = 32'h0000_0080;
   localparam logic [31:0] PID  = 32'h1 << CTRL_PID;
   localparam logic [31:0] PAR  = 32'h1 << CTRL_PARAM;

   logic          clock_i = 1'b0;
   logic          rst_n_i = 1'b0;
   logic [7:0]    addr_i = 8'h00;
   logic [31:0]   wdata_i = 32'h0;
   logic          wr_i = 1'b0;
   logic          rd_i = 1'b0;
   logic          run_i = 1'b0;
   logic [1:0]    sel_i = 2'h0;
   logic          spk_i = 1'b0;
   logic          dnk_i = 1'b0;
   logic          cfk_i = 1'b0;
   logic          exk_i = 1'b0;
   logic [W-1:0]  meas_i = 16'h0;
   logic [W-1:0]  ext_i = 16'h0;
   logic [31:0]   rdata_o;
   logic [W-1:0]  loop_o, nvsp_o, drive_o, kp_o, ki_o, kd_o, sp_o, off_o, sf_o, sr_o, nvd_o;
   logic          reg_o, nvs_o;
   logic [W-1:0]  trim_o;
   logic [31:0]   v;
   int            err_total = 0;
   int            n_compared = 0;
   int            cyc = 0;

   always #4 clock_i = ~clock_i;

   tlrc_run_ctrl #(.W(W), .HOLD_CYCLES(20)) tlrc_run_ctrl_i (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .run_req_pin_i(run_i), .gain_sel_pin_i(sel_i), .sp_key_pin_i(spk_i),
      .down_key_pin_i(dnk_i), .confirm_key_pin_i(cfk_i), .exit_key_pin_i(exk_i),
      .meas_i(meas_i), .ext_sp_i(ext_i), .loop_out_i(loop_o), .nv_setpoint_i(nvsp_o),
      .drive_o(drive_o), .regulating_o(reg_o), .kp_o(kp_o), .ki_o(ki_o), .kd_o(kd_o),
      .trim_share_o(trim_o), .setpoint_o(sp_o), .offset_o(off_o), .span_force_o(sf_o),
      .span_reading_o(sr_o), .nv_store_o(nvs_o), .nv_data_o(nvd_o));

   tlrc_far_side #(.W(W), .NV_INIT(NV0)) tlrc_far_side_i (
      .clock_i(clock_i), .setpoint_i(sp_o), .kp_i(kp_o), .nv_store_i(nvs_o),
      .nv_data_i(nvd_o), .loop_out_o(loop_o), .nv_setpoint_o(nvsp_o));

   task automatic give_verdict();
      if (err_total == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask

   function automatic logic [15:0] gv(input int s, input int k);
      return 16'(16'h1000 * (s + 1) + k + 1);
   endfunction

   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         give_verdict();
      end
   end

   initial begin
      repeat (8) @(posedge clock_i);
      rst_n_i <= 1'b1;
      wt(4);
      chk("drive_reset", 32'h0, drive_o);
      chk("reg_reset", 32'h0, reg_o);
      chk("sp_nv", NV0, sp_o);
      rd(8'h30, v);
      chk("unmapped", 32'h0, v);
      for (int f = 0; f < 4; f++) begin
         wr(ADDR_CTRL, 32'(f) << CTRL_FMT_LO);
         wt(3);
         chk("idle_fmt", (f == 2) ? IDLE_4MA_CODE : 16'h0, drive_o);
      end
      wr(ADDR_CTRL, BASE | PAR | PID);
      for (int s = 0; s < 4; s++) begin
         for (int k = 0; k < 3; k++) begin
            wr(8'(8'h40 + 4 * (s * 3 + k)), 32'(gv(s, k)));
         end
      end
      wr(ADDR_TRIM, 32'h0055);
      wt(2);
      chk("trim_shadow", 32'h0, trim_o);
      wr(ADDR_CTRL, BASE | PID);
      wt(2);
      chk("trim_applied", 32'h0055, trim_o);
      for (int s = 0; s < 4; s++) begin
         sel_i <= 2'(s);
         wt(8);
         chk("kp_set", gv(s, 0), kp_o);
         chk("ki_set", gv(s, 1), ki_o);
         chk("kd_set", gv(s, 2), kd_o);
         rd(ADDR_STATUS, v);
         chk("act_set", 32'(s), {30'h0, v[4:3]});
      end
      wr(ADDR_CTRL, BASE | PAR);
      wr(ADDR_CTRL, BASE);
      wt(2);
      chk("kd_pi", 32'h0, kd_o);
      wr(ADDR_CTRL, BASE | PAR | PID);
      wr(ADDR_CTRL, BASE | PID);
      sel_i <= 2'h1;
      wt(8);
      run_i <= 1'b1;
      wt(8);
      chk("reg_pin", 32'h1, reg_o);
      chk("drive_run", 16'(NV0 + gv(1, 0)), drive_o);
      sel_i <= 2'h2;
      wt(8);
      chk("kp_frozen", gv(1, 0), kp_o);
      wr(ADDR_CTRL, BASE | PAR | PID);
      wr(8'h4C, 32'h7777);
      wt(2);
      chk("kp_shadow", gv(1, 0), kp_o);
      wr(ADDR_CTRL, BASE | PID);
      wt(2);
      chk("kp_applied", 32'h7777, kp_o);
      wr(ADDR_SETPOINT, 32'h0456);
      wt(2);
      chk("sp_host_run", 32'h0456, sp_o);
      chk("reg_kept", 32'h1, reg_o);
      run_i <= 1'b0;
      wt(8);
      chk("reg_off", 32'h0, reg_o);
      chk("drive_off", IDLE_4MA_CODE, drive_o);
      wr(ADDR_CTRL, BASE | PID | (32'h1 << CTRL_EN_CMD));
      wt(2);
      chk("reg_serial", 32'h1, reg_o);
      run_i <= 1'b1;
      wt(8);
      run_i <= 1'b0;
      wt(8);
      chk("pin_ignored", 32'h1, reg_o);
      wr(ADDR_CTRL, BASE | PID | (32'h1 << CTRL_DIS_CMD));
      wt(2);
      chk("serial_off", 32'h0, reg_o);
      wr(ADDR_SCALE, 32'h0200);
      ext_i <= 16'h0150;
      wr(ADDR_CTRL, BASE | PID | (32'h1 << CTRL_SP_EXT));
      wr(ADDR_SETPOINT, 32'h0999);
      wt(3);
      chk("sp_ext", 32'h02A0, sp_o);
      wr(ADDR_CTRL, BASE | PID);
      spk_i <= 1'b1;
      wt(15);
      spk_i <= 1'b0;
      wt(8);
      spk_i <= 1'b1;
      wt(15);
      spk_i <= 1'b0;
      rd(ADDR_STATUS, v);
      chk("edit_short", 32'h0, v[2]);
      spk_i <= 1'b1;
      wt(30);
      spk_i <= 1'b0;
      rd(ADDR_STATUS, v);
      chk("edit_hold", 32'h1, v[2]);
      wr(ADDR_EDIT, 32'h0ABC);
      cfk_i <= 1'b1;
      wt(8);
      cfk_i <= 1'b0;
      chk("nv_saved", 32'h0ABC, nvsp_o);
      chk("sp_saved", 32'h0ABC, sp_o);
      spk_i <= 1'b1;
      wt(30);
      spk_i <= 1'b0;
      wr(ADDR_EDIT, 32'h0DEF);
      exk_i <= 1'b1;
      wt(8);
      exk_i <= 1'b0;
      wt(2);
      chk("sp_volatile", 32'h0DEF, sp_o);
      chk("nv_kept", 32'h0ABC, nvsp_o);
      wr(ADDR_CTRL, BASE | PAR | PID);
      wr(ADDR_CTRL, BASE | PID);
      wt(2);
      chk("sp_dropped", 32'h0ABC, sp_o);
      meas_i <= 16'h0040;
      wr(ADDR_CTRL, BASE | PID | (32'h1 << CTRL_ZERO_CAP));
      dnk_i <= 1'b1;
      wt(30);
      dnk_i <= 1'b0;
      chk("offset", 32'h0040, off_o);
      meas_i <= 16'h0540;
      wr(ADDR_CTRL, BASE | PID | (32'h1 << CTRL_SPAN_CAP));
      wr(ADDR_SPAN, 32'h0250);
      wt(2);
      chk("span_force", 32'h0250, sf_o);
      chk("span_reading", 32'h0500, sr_o);
      give_verdict();
   end
endmodule
